// File: pfs_codec_model.sv
// codec stand-in on the far side of the sample link
// assumes the bench calls its tasks in the bus clock domain
`timescale 1ns/10ps
module pfs_codec_model
  import pfs_pkg::*;
(
  input wire logic clock_in, // bus clock
  input wire logic [PFS_DW-1:0] tx_data_in, // head of tx fifo
  output logic push_out, // sample into rx fifo
  output logic [PFS_DW-1:0] data_out, // sample value
  output logic pop_out // take tx head
);
  // idle link at time zero
  initial begin
    push_out = 1'b0;
    pop_out = 1'b0;
    data_out = 16'h0;
  end
  // one-cycle push; data is inverted after, so a stale sample never looks right
  task automatic push(input logic [PFS_DW-1:0] d);
    @(posedge clock_in);
    push_out <= 1'b1;
    data_out <= d;
    @(posedge clock_in);
    push_out <= 1'b0;
    data_out <= ~d;
  endtask
  // pops even when empty, since the underrun case is commanded by the bench
  task automatic pop(output logic [PFS_DW-1:0] d);
    @(posedge clock_in);
    pop_out <= 1'b1;
    @(posedge clock_in);
    d = tx_data_in;
    pop_out <= 1'b0;
  endtask
endmodule // pfs_codec_model

// File: pfs_fifo.sv
// 16 x 16 flip-flop fifo with synchronous clear
// assumes push on full and pop on empty are filtered here; the caller flags all of them except a pop on the empty rx fifo
`timescale 1ns/10ps
module pfs_fifo
  import pfs_pkg::*;
(
  input wire logic clock_in, // bus clock
  input wire logic arst_n_in, // async reset, low
  pfs_fifo_if.mem f // push/pop side
);
  typedef struct packed {
    logic [PFS_DEPTH-1:0][PFS_DW-1:0] mem;
    logic [PFS_PW-1:0] wp;
    logic [PFS_PW-1:0] rp;
    logic [PFS_PW:0] cnt;
  } pfs_fifo_st_t;
  pfs_fifo_st_t st, next_st;
  logic do_push, do_pop;

  // guarded strobes keep pointers sane under misuse
  always_comb begin
    do_push = f.push && (st.cnt != PFS_PW'(0) + (PFS_PW+1)'(PFS_DEPTH));
    do_pop = f.pop && (st.cnt != '0);
    next_st = st;
    if (f.clr) begin
      next_st.wp = '0;
      next_st.rp = '0;
      next_st.cnt = '0;
    end else begin
      if (do_push) begin
        next_st.mem[st.wp] = f.wdata;
        next_st.wp = st.wp + 1'b1;
      end
      if (do_pop) next_st.rp = st.rp + 1'b1;
      if (do_push && !do_pop) next_st.cnt = st.cnt + 1'b1;
      if (do_pop && !do_push) next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) st <= '0;
    else st <= next_st;
  end

  assign f.rdata = st.mem[st.rp];
  assign f.full = st.cnt[PFS_PW];
  assign f.empty = (st.cnt == '0);
endmodule // pfs_fifo

// File: pfs_fifo_if.sv
// push/pop carrier between the top and one fifo
// assumes a single clock domain
`timescale 1ns/10ps
interface pfs_fifo_if;
  import pfs_pkg::*;
  logic push;
  logic pop;
  logic clr;
  logic [PFS_DW-1:0] wdata;
  logic [PFS_DW-1:0] rdata;
  logic full;
  logic empty;
  modport ctl (output push, pop, clr, wdata, input rdata, full, empty);
  modport mem (input push, pop, clr, wdata, output rdata, full, empty);
endinterface

// File: pfs_pkg.sv
// package for the pcm fifo status and data-port block
// assumes a single bus clock and the plain register port of the top module
package pfs_pkg;
  localparam int unsigned PFS_AW = 16;
  localparam int unsigned PFS_DW = 16;
  localparam int unsigned PFS_DEPTH = 16;
  localparam int unsigned PFS_PW = 4;
  localparam logic [PFS_AW-1:0] PFS_OFF_STATUS = 16'h0004;
  localparam logic [PFS_AW-1:0] PFS_OFF_RX = 16'h0008;
  localparam logic [PFS_AW-1:0] PFS_OFF_TX = 16'h000c;
  localparam logic [PFS_AW-1:0] PFS_OFF_IRQ_EN = 16'h0010;
  localparam logic [PFS_AW-1:0] PFS_OFF_IRQ_CLR = 16'h0014;
  localparam logic [PFS_AW-1:0] PFS_OFF_FIFO_RST = 16'h0018;
  localparam logic [PFS_AW-1:0] PFS_INST_STRIDE = 16'h8000;
  localparam int unsigned PFS_B_TX_EMPTY = 7;
  localparam int unsigned PFS_B_RX_FULL = 6;
  localparam int unsigned PFS_B_TX_FULL = 5;
  localparam int unsigned PFS_B_RX_EMPTY = 4;
  localparam int unsigned PFS_B_TX_ERR = 3;
  localparam int unsigned PFS_B_RX_ERR = 2;
  localparam int unsigned PFS_B_TX_IRQ = 1;
  localparam int unsigned PFS_B_RX_IRQ = 0;
  localparam int unsigned PFS_NEV = 4;
  localparam logic [PFS_NEV-1:0] PFS_PEND_RST = 4'h2;
  localparam logic [PFS_NEV-1:0] PFS_EN_RST = 4'h0;
endpackage

// File: pfs_top.sv
// status register, data ports and two sample fifos of one pcm instance
// assumes the codec side supplies rx push and tx pop strobes in the bus clock
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module pfs_top
  import pfs_pkg::*;
#(
  parameter logic INSTANCE = 1'b0 // instance number, 0 or 1
) (
  input wire logic clock_in, // bus clock, 25 MHz
  input wire logic arst_n_in, // async reset, low
  input wire logic [PFS_AW-1:0] addr_in, // byte address
  input wire logic [31:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic link_rx_push_in, // codec sample arrives
  input wire logic [PFS_DW-1:0] link_rx_data_in, // codec sample
  input wire logic link_tx_pop_in, // codec takes a sample
  output logic [31:0] rdata_out, // read data, cycle after rd
  output logic [PFS_DW-1:0] link_tx_data_out, // sample to codec
  output logic link_tx_valid_out, // tx sample valid
  output logic irq_out // level interrupt
);
  typedef struct packed {
    logic [31:0] rdata;
    logic [PFS_NEV-1:0] pend;
    logic [PFS_NEV-1:0] en;
    logic [PFS_DW-1:0] txd;
    logic txv;
    logic irq;
  } pfs_st_t;
  pfs_st_t st, next_st;

  pfs_fifo_if rxf ();
  pfs_fifo_if txf ();
  pfs_fifo u_rx (.clock_in(clock_in), .arst_n_in(arst_n_in), .f(rxf.mem));
  pfs_fifo u_tx (.clock_in(clock_in), .arst_n_in(arst_n_in), .f(txf.mem));

  // instance base folded in so both instances share one decoder
  function automatic logic hit(input logic [PFS_AW-1:0] a, input logic [PFS_AW-1:0] off);
    hit = (a == (off | (INSTANCE ? PFS_INST_STRIDE : '0)));
  endfunction

  logic wr_stat, wr_tx, rd_rx, wr_en, wr_clr, wr_frst;
  logic tx_err_ev, rx_err_ev, tx_irq_ev, rx_irq_ev;
  logic [7:0] status;
  logic [PFS_NEV-1:0] set_v, clr_v;

  // decode
  always_comb begin
    wr_stat = wr_in && hit(addr_in, PFS_OFF_STATUS);
    wr_tx = wr_in && hit(addr_in, PFS_OFF_TX);
    rd_rx = rd_in && hit(addr_in, PFS_OFF_RX);
    wr_en = wr_in && hit(addr_in, PFS_OFF_IRQ_EN);
    wr_clr = wr_in && hit(addr_in, PFS_OFF_IRQ_CLR);
    wr_frst = wr_in && hit(addr_in, PFS_OFF_FIFO_RST);
  end

  // fifo strobes; clears come from the reset register
  assign rxf.push = link_rx_push_in;
  assign rxf.wdata = link_rx_data_in;
  assign rxf.pop = rd_rx;
  assign rxf.clr = wr_frst && wdata_in[PFS_B_RX_ERR];
  assign txf.push = wr_tx;
  assign txf.wdata = wdata_in[PFS_DW-1:0];
  assign txf.pop = link_tx_pop_in;
  assign txf.clr = wr_frst && wdata_in[PFS_B_TX_ERR];

  // error and interrupt events
  assign tx_err_ev = (wr_tx && txf.full) || (link_tx_pop_in && txf.empty);
  assign rx_err_ev = link_rx_push_in && rxf.full;
  assign tx_irq_ev = link_tx_pop_in && !txf.empty;
  assign rx_irq_ev = link_rx_push_in && !rxf.full;

  assign status = {txf.empty, rxf.full, txf.full, rxf.empty, st.pend};

  // pending bits: set wins over any clear in the same cycle
  always_comb begin
    set_v = {tx_err_ev, rx_err_ev, tx_irq_ev, rx_irq_ev};
    clr_v = '0;
    if (wr_stat) clr_v = clr_v | wdata_in[PFS_NEV-1:0];
    if (wr_clr) clr_v = clr_v | wdata_in[PFS_NEV-1:0];
    if (txf.clr) clr_v[PFS_B_TX_ERR] = 1'b1;
    if (rxf.clr) clr_v[PFS_B_RX_ERR] = 1'b1;
    next_st = st;
    next_st.pend = (st.pend & ~clr_v) | set_v;
    if (wr_en) next_st.en = wdata_in[PFS_NEV-1:0];
    next_st.rdata = '0;
    if (rd_in && hit(addr_in, PFS_OFF_STATUS)) next_st.rdata = {24'h0, status};
    else if (rd_rx) next_st.rdata = {16'h0, rxf.rdata};
    else if (rd_in && hit(addr_in, PFS_OFF_IRQ_EN)) next_st.rdata = {28'h0, st.en};
    next_st.irq = |(next_st.pend & next_st.en);
    next_st.txd = txf.rdata;
    next_st.txv = !txf.empty;
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
      st.pend <= PFS_PEND_RST;
      st.en <= PFS_EN_RST;
    end else st <= next_st;
  end

  assign rdata_out = st.rdata;
  assign link_tx_data_out = st.txd;
  assign link_tx_valid_out = st.txv;
  assign irq_out = st.irq;

  // checks
  property p_tx_err;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_tx && txf.full) |=> st.pend[PFS_B_TX_ERR];
  endproperty
  a_tx_err: assert property (p_tx_err) else $error("tx error not set");
  property p_rx_err;
    @(posedge clock_in) disable iff (!arst_n_in)
      (link_rx_push_in && rxf.full) |=> st.pend[PFS_B_RX_ERR];
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("rx error not set");
  property p_w1c_tx;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_stat && wdata_in[PFS_B_TX_ERR] && !tx_err_ev) |=> !st.pend[PFS_B_TX_ERR];
  endproperty
  a_w1c_tx: assert property (p_w1c_tx) else $error("tx error not cleared");
  property p_frst;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rxf.clr && !rx_err_ev) |=> !st.pend[PFS_B_RX_ERR] && rxf.empty;
  endproperty
  a_frst: assert property (p_frst) else $error("fifo reset left error");
  property p_w1c_irq;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_stat && wdata_in[PFS_B_TX_IRQ] && !tx_irq_ev) |=> !st.pend[PFS_B_TX_IRQ];
  endproperty
  a_w1c_irq: assert property (p_w1c_irq) else $error("tx irq not cleared");
  property p_rx_irq;
    @(posedge clock_in) disable iff (!arst_n_in)
      rx_irq_ev |=> st.pend[PFS_B_RX_IRQ];
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq not set");
  property p_rx_read;
    @(posedge clock_in) disable iff (!arst_n_in)
      rd_rx |=> rdata_out == {16'h0, $past(rxf.rdata)};
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("rx port data wrong");
  property p_stat_read;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rd_in && hit(addr_in, PFS_OFF_STATUS)) |=> rdata_out[31:8] == 24'h0
        && rdata_out[PFS_B_TX_EMPTY] == $past(txf.empty);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");
  property p_tx_push;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_tx && !txf.full && !txf.pop && !txf.clr) |=> !txf.empty;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("tx push lost");
  c_rx_full: cover property (@(posedge clock_in) rxf.full);
  c_tx_err: cover property (@(posedge clock_in) tx_err_ev);

  // flag nibble of a status read must match the fifo state at the read edge
  property p_stat_flags;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rd_in && hit(addr_in, PFS_OFF_STATUS)) |=> rdata_out[7:4] == $past(status[7:4]);
  endproperty
  a_stat_flags: assert property (p_stat_flags) else $error("status flags wrong");

  // pending nibble read back as it stood at the read edge
  property p_stat_pend;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rd_in && hit(addr_in, PFS_OFF_STATUS)) |=> rdata_out[3:0] == $past(st.pend);
  endproperty
  a_stat_pend: assert property (p_stat_pend) else $error("pending bits read wrong");

  // write 1 clears the rx error unless a new overflow lands in the same cycle
  property p_w1c_rx;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_stat && wdata_in[PFS_B_RX_ERR] && !rx_err_ev) |=> !st.pend[PFS_B_RX_ERR];
  endproperty
  a_w1c_rx: assert property (p_w1c_rx) else $error("rx error not cleared");

  // write 1 clears the rx interrupt unless a new sample lands with it
  property p_w1c_rxirq;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_stat && wdata_in[PFS_B_RX_IRQ] && !rx_irq_ev) |=> !st.pend[PFS_B_RX_IRQ];
  endproperty
  a_w1c_rxirq: assert property (p_w1c_rxirq) else $error("rx irq not cleared");

  // the separate clear register acts like a status write
  property p_clr_reg;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_clr && wdata_in[PFS_B_RX_IRQ] && !rx_irq_ev) |=> !st.pend[PFS_B_RX_IRQ];
  endproperty
  a_clr_reg: assert property (p_clr_reg) else $error("clear register ignored");

  // a sample taken by the codec raises the tx interrupt
  property p_tx_irq_set;
    @(posedge clock_in) disable iff (!arst_n_in)
      tx_irq_ev |=> st.pend[PFS_B_TX_IRQ];
  endproperty
  a_tx_irq_set: assert property (p_tx_irq_set) else $error("tx irq not set");

  // tx fifo reset empties it and drops its error flag
  property p_tx_frst;
    @(posedge clock_in) disable iff (!arst_n_in)
      (txf.clr && !tx_err_ev) |=> !st.pend[PFS_B_TX_ERR] && txf.empty;
  endproperty
  a_tx_frst: assert property (p_tx_frst) else $error("tx fifo reset left error");

  // codec pulling from an empty tx fifo is an underrun
  property p_underrun;
    @(posedge clock_in) disable iff (!arst_n_in)
      (link_tx_pop_in && txf.empty) |=> st.pend[PFS_B_TX_ERR];
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not flagged");

  // no error flag appears without its event
  property p_no_tx_err;
    @(posedge clock_in) disable iff (!arst_n_in)
      (!st.pend[PFS_B_TX_ERR] && !tx_err_ev) |=> !st.pend[PFS_B_TX_ERR];
  endproperty
  a_no_tx_err: assert property (p_no_tx_err) else $error("spurious tx error");

  property p_no_rx_err;
    @(posedge clock_in) disable iff (!arst_n_in)
      (!st.pend[PFS_B_RX_ERR] && !rx_err_ev) |=> !st.pend[PFS_B_RX_ERR];
  endproperty
  a_no_rx_err: assert property (p_no_rx_err) else $error("spurious rx error");

  // an overflowing push is dropped, so the fifo stays full
  property p_rx_full_hold;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rx_err_ev && !rd_rx && !rxf.clr) |=> rxf.full;
  endproperty
  a_rx_full_hold: assert property (p_rx_full_hold) else $error("rx full lost");

  // reading a full rx fifo frees one entry
  property p_rx_pop;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rd_rx && rxf.full && !rxf.push && !rxf.clr) |=> !rxf.full;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx read did not pop");

  // upper half of the rx port always reads zero
  property p_rx_upper;
    @(posedge clock_in) disable iff (!arst_n_in)
      rd_rx |=> rdata_out[31:16] == 16'h0;
  endproperty
  a_rx_upper: assert property (p_rx_upper) else $error("rx upper bits set");

  // read data stand one cycle only, zero otherwise
  property p_rdata_idle;
    @(posedge clock_in) disable iff (!arst_n_in)
      !rd_in |=> rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  // a dropped write to a full tx fifo leaves it full
  property p_tx_full_hold;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_tx && txf.full && !txf.pop && !txf.clr) |=> txf.full;
  endproperty
  a_tx_full_hold: assert property (p_tx_full_hold) else $error("tx full lost");

  // the other instance's window must never answer a read here
  property p_other_rd;
    @(posedge clock_in) disable iff (!arst_n_in)
      (rd_in && addr_in[PFS_AW-1] != INSTANCE) |=> rdata_out == 32'h0;
  endproperty
  a_other_rd: assert property (p_other_rd) else $error("foreign read answered");

  // nor may its tx writes fill this fifo
  property p_other_wr;
    @(posedge clock_in) disable iff (!arst_n_in)
      (wr_in && addr_in[PFS_AW-1] != INSTANCE && txf.empty) |=> txf.empty;
  endproperty
  a_other_wr: assert property (p_other_wr) else $error("foreign write taken");

  // link side shows the head one cycle late, valid while not empty
  property p_txv;
    @(posedge clock_in) disable iff (!arst_n_in)
      1'b1 |=> link_tx_valid_out == !$past(txf.empty);
  endproperty
  a_txv: assert property (p_txv) else $error("tx valid wrong");

  property p_txd;
    @(posedge clock_in) disable iff (!arst_n_in)
      !txf.empty |=> link_tx_data_out == $past(txf.rdata);
  endproperty
  a_txd: assert property (p_txd) else $error("tx head wrong");

  // interrupt is a plain level of enabled pending bits
  property p_irq_level;
    @(posedge clock_in) disable iff (!arst_n_in)
      1'b1 |-> irq_out == |(st.pend & st.en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  c_irq: cover property (@(posedge clock_in) irq_out);
  c_frst: cover property (@(posedge clock_in) rxf.clr);
  c_clr_reg: cover property (@(posedge clock_in) wr_clr);
endmodule // pfs_top

// File: pfs_top_tb.sv
// self-checking bench for the pcm fifo status and data-port block
// assumes instance 0 and the codec stand-in on the sample link
`timescale 1ns/10ps
module pfs_top_tb;
  import pfs_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [PFS_AW-1:0] addr = 16'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic push, pop, irq, txv;
  logic [PFS_DW-1:0] rxd, txd, smp;
  logic [31:0] rdata, got;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // 25 mhz bus clock
  always #20 clock_in = ~clock_in;
  pfs_codec_model codec (.clock_in(clock_in), .tx_data_in(txd), .push_out(push),
    .data_out(rxd), .pop_out(pop));
  pfs_top #(.INSTANCE(1'b0)) dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .link_rx_push_in(push),
    .link_rx_data_in(rxd), .link_tx_pop_in(pop), .rdata_out(rdata),
    .link_tx_data_out(txd), .link_tx_valid_out(txv), .irq_out(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [PFS_AW-1:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [PFS_AW-1:0] a, output logic [31:0] d);
    @(posedge clock_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic st(input logic [31:0] exp);
    rd_reg(PFS_OFF_STATUS, got);
    chk(got, exp);
  endtask
  task automatic t_tx_single;
    wr_reg(PFS_OFF_STATUS, 32'h2);
    st(32'h90);
    wr_reg(PFS_OFF_TX, 32'habcd1234);
    st(32'h10);
    chk({31'h0, txv}, 32'h1);
    codec.pop(smp);
    chk({16'h0, smp}, 32'h1234);
    st(32'h92);
    codec.pop(smp);
    st(32'h9a);
    chk({31'h0, txv}, 32'h0);
    wr_reg(PFS_OFF_IRQ_EN, 32'h8);
    @(posedge clock_in);
    #1 chk({31'h0, irq}, 32'h1);
    wr_reg(PFS_OFF_STATUS, 32'ha);
    st(32'h90);
  endtask
  // sixteen fit, the seventeenth is dropped and flagged
  task automatic t_tx_fill;
    for (int i = 0; i < PFS_DEPTH; i++) begin
      wr_reg(PFS_OFF_TX, 32'h100 + i);
    end
    st(32'h30);
    wr_reg(PFS_OFF_TX, 32'hffff);
    st(32'h38);
    wr_reg(PFS_OFF_FIFO_RST, 32'h8);
    st(32'h90);
  endtask
  task automatic t_rx_fill;
    for (int i = 0; i < PFS_DEPTH; i++) begin
      codec.push(16'(16'h5a00 + i));
    end
    st(32'hc1);
    codec.push(16'hbeef);
    st(32'hc5);
    wr_reg(PFS_OFF_STATUS, 32'h5);
    st(32'hc0);
    for (int i = 0; i < PFS_DEPTH; i++) begin
      rd_reg(PFS_OFF_RX, got);
      chk(got, 32'h5a00 + i);
    end
    st(32'h90);
  endtask
  // other instance and unmapped places must not answer
  task automatic t_decode;
    rd_reg(PFS_OFF_RX + PFS_INST_STRIDE, got);
    chk(got, 32'h0);
    wr_reg(PFS_OFF_TX + PFS_INST_STRIDE, 32'h1);
    st(32'h90);
    rd_reg(16'h001c, got);
    chk(got, 32'h0);
  endtask
  // enable readback, rx fifo reset and the separate clear register
  task automatic t_irq_paths;
    wr_reg(PFS_OFF_IRQ_EN, 32'h1);
    rd_reg(PFS_OFF_IRQ_EN, got);
    chk(got, 32'h1);
    codec.push(16'h0077);
    st(32'h81);
    chk({31'h0, irq}, 32'h1);
    wr_reg(PFS_OFF_FIFO_RST, 32'h4);
    st(32'h91);
    wr_reg(PFS_OFF_IRQ_CLR, 32'h1);
    st(32'h90);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic results;
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 170 cycles the run needs
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results;
    end
  end
  initial begin
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b1;
    st(32'h92);
    t_tx_single;
    t_tx_fill;
    t_rx_fill;
    t_decode;
    t_irq_paths;
    results;
  end
endmodule // pfs_top_tb
